// [rtl/coa_core.sv]
`timescale 1ns/100ps
`include "coa_defines.svh"
module coa_core #(
  parameter logic [31:0] RESET_PC = 32'h0000_0000
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // memory bus
  output coa_pkg::coa_mem_req_type      mem_o,
  input  wire logic                     mem_ack,
  input  wire logic [31:0]              mem_rdata,
  // visible state
  output logic                          cond_flag,
  output logic [31:0]                   pc_o,
  output logic [63:0]                   mac_o,
  output logic                          retire_o
);

  // odd start address cannot hold a 16-bit instruction
  if (RESET_PC[0]) begin : g_chk
    $error("RESET_PC must be halfword aligned");
  end

  coa_pkg::coa_state_type   state_r;
  coa_pkg::coa_insn_type    insn_r;
  coa_pkg::coa_mem_req_type mem_r;
  logic [31:0] rf_r [16];
  logic        flag_r;
  logic [31:0] pc_r;
  logic        pend_r;
  logic [31:0] tgt_r;
  logic [63:0] mac_r;
  logic [63:0] prod_r;
  logic [1:0]  cnt_r;

  logic [31:0] rn_v;
  logic [31:0] rm_v;
  logic [31:0] r0_v;
  logic [31:0] base_v;
  logic [3:0]  base_idx;
  logic [31:0] imm_s;
  logic [31:0] step;
  logic [31:0] ea;
  logic [31:0] lit_ea;
  logic [31:0] br_tgt;
  logic [31:0] bra_tgt;
  logic [31:0] ld_ext;
  logic [63:0] prod_nxt;
  logic [63:0] mul16_v;
  logic [63:0] mul32_v;
  logic [1:0]  lat;
  logic [1:0]  am;
  logic        is_ldst;
  logic        need_mem;
  logic        need_mul;
  logic        taken;
  logic        in_exec;
  logic        retire;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // operand fetch from the register file
  assign rn_v     = rf_r[insn_r.rn];
  assign rm_v     = rf_r[insn_r.rm];
  assign r0_v     = rf_r[`COA_IDX_REG];
  assign imm_s    = {{24{insn_r.rm[3]}}, insn_r.rm, insn_r.sub};
  assign am       = insn_r.sub[3:2];
  assign in_exec  = (state_r == coa_pkg::ST_EXEC);
  assign is_ldst  = (insn_r.op == `COA_OP_LD) || (insn_r.op == `COA_OP_ST);
  assign need_mem = is_ldst || (insn_r.op == `COA_OP_LITW) || (insn_r.op == `COA_OP_LITL);
  assign need_mul = (insn_r.op == `COA_OP_MUL);

  // loads address through rm, stores through rn
  assign base_idx = (insn_r.op == `COA_OP_LD) ? insn_r.rm : insn_r.rn;
  assign base_v   = rf_r[base_idx];

  // address step from access size
  always_comb begin
    case (insn_r.sub[1:0])
      `COA_SZ_B: step = `COA_STEP_B;
      `COA_SZ_W: step = `COA_STEP_W;
      default:   step = `COA_STEP_L;
    endcase
  end

  // effective address per mode
  always_comb begin
    if (am == `COA_AM_PRE) begin
      ea = base_v - step;
    end else if (am == `COA_AM_IDX) begin
      ea = base_v + r0_v;
    end else begin
      ea = base_v;
    end
  end

  // literal table address, long entries word aligned
  always_comb begin
    if (insn_r.op == `COA_OP_LITL) begin
      lit_ea = {pc_r[31:2], 2'b00} + {22'h0, insn_r.rm, insn_r.sub, 2'b00};
    end else begin
      lit_ea = pc_r + {23'h0, insn_r.rm, insn_r.sub, 1'b0};
    end
  end

  // branch targets relative to the branch itself
  assign br_tgt  = pc_r + {{23{insn_r.rm[3]}}, insn_r.rm, insn_r.sub, 1'b0};
  assign bra_tgt = pc_r + {{19{insn_r.rn[3]}}, insn_r.rn, insn_r.rm, insn_r.sub, 1'b0};

  // conditional branches look at the flag and nothing else
  assign taken = ((insn_r.op == `COA_OP_BT) && flag_r) ||
                 ((insn_r.op == `COA_OP_BF) && !flag_r);

  // load data sign extension
  always_comb begin
    case (mem_r.size)
      `COA_SZ_B: ld_ext = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
      `COA_SZ_W: ld_ext = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
      default:   ld_ext = mem_rdata;
    endcase
  end

  // sign-extended 64-bit products; low 64 bits are exact for signed operands
  assign mul16_v = {{48{rn_v[15]}}, rn_v[15:0]} * {{48{rm_v[15]}}, rm_v[15:0]};
  assign mul32_v = {{32{rn_v[31]}}, rn_v} * {{32{rm_v[31]}}, rm_v};

  // multiply result and its latency
  always_comb begin
    case (insn_r.sub[1:0])
      // operands widened first so the product is never cut by context
      `COA_MK_S16: begin
        prod_nxt = {mac_r[63:32], mul16_v[31:0]};
        lat      = `COA_LAT_S16;
      end
      `COA_MK_M16: begin
        prod_nxt = mac_r + mul16_v;
        lat      = `COA_LAT_M16;
      end
      `COA_MK_S32: begin
        prod_nxt = mul32_v;
        lat      = `COA_LAT_32;
      end
      default: begin
        prod_nxt = mac_r + mul32_v;
        lat      = `COA_LAT_32;
      end
    endcase
  end

  // one pulse per finished instruction
  assign retire = (in_exec && !need_mem && !need_mul) ||
                  ((state_r == coa_pkg::ST_MEM) && mem_ack && mem_r.req) ||
                  ((state_r == coa_pkg::ST_MUL) && (cnt_r == 2'h1));

  // sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= coa_pkg::ST_FETCH;
    end else begin
      case (state_r)
        coa_pkg::ST_FETCH: begin
          if (mem_r.req && mem_ack) state_r <= coa_pkg::ST_EXEC;
        end
        coa_pkg::ST_EXEC: begin
          if (need_mem) begin
            state_r <= coa_pkg::ST_MEM;
          end else if (need_mul) begin
            state_r <= coa_pkg::ST_MUL;
          end else begin
            state_r <= coa_pkg::ST_FETCH;
          end
        end
        coa_pkg::ST_MEM: begin
          if (mem_r.req && mem_ack) state_r <= coa_pkg::ST_FETCH;
        end
        default: begin
          if (cnt_r == 2'h1) state_r <= coa_pkg::ST_FETCH;
        end
      endcase
    end
  end

  // instruction register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      insn_r <= '0;
    end else if ((state_r == coa_pkg::ST_FETCH) && mem_r.req && mem_ack) begin
      insn_r <= mem_rdata[15:0];
    end
  end

  // bus requests held until acknowledged
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_r <= '0;
    end else if (mem_r.req && mem_ack) begin
      mem_r.req <= 1'b0;
      mem_r.we  <= 1'b0;
    end else if ((state_r == coa_pkg::ST_FETCH) && !mem_r.req) begin
      mem_r <= {1'b1, 1'b0, `COA_SZ_W, pc_r, 32'h0000_0000};
    end else if (in_exec && is_ldst) begin
      mem_r.req   <= 1'b1;
      mem_r.we    <= (insn_r.op == `COA_OP_ST);
      mem_r.size  <= insn_r.sub[1:0];
      mem_r.addr  <= ea;
      mem_r.wdata <= rm_v;
    end else if (in_exec && need_mem) begin
      // literal entry fetched like any load
      mem_r.req   <= 1'b1;
      mem_r.we    <= 1'b0;
      mem_r.size  <= (insn_r.op == `COA_OP_LITL) ? `COA_SZ_L : `COA_SZ_W;
      mem_r.addr  <= lit_ea;
      mem_r.wdata <= 32'h0000_0000;
    end
  end

  // program counter and delayed branch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pc_r   <= RESET_PC;
      pend_r <= 1'b0;
      tgt_r  <= 32'h0000_0000;
    end else if (retire) begin
      if (pend_r) begin
        // a branch sitting in the slot is not honoured
        pc_r   <= tgt_r;
        pend_r <= 1'b0;
      end else if (taken) begin
        pc_r <= br_tgt;
      end else begin
        pc_r <= pc_r + `COA_INSN_STEP;
        if (insn_r.op == `COA_OP_BRA) begin
          pend_r <= 1'b1;
          tgt_r  <= bra_tgt;
        end
      end
    end
  end

  // general registers; base update at execute, load data on ack
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) rf_r[i] <= 32'h0000_0000;
    end else if (in_exec) begin
      case (insn_r.op)
        `COA_OP_MOVI: rf_r[insn_r.rn] <= imm_s;
        `COA_OP_ADDI: rf_r[insn_r.rn] <= rn_v + imm_s;
        `COA_OP_ADD:  rf_r[insn_r.rn] <= rn_v + rm_v;
        `COA_OP_MOV:  rf_r[insn_r.rn] <= rm_v;
        `COA_OP_LD, `COA_OP_ST: begin
          if (am == `COA_AM_POST) rf_r[base_idx] <= base_v + step;
          if (am == `COA_AM_PRE)  rf_r[base_idx] <= base_v - step;
        end
        default: ;
      endcase
    end else if ((state_r == coa_pkg::ST_MEM) && mem_r.req && mem_ack && !mem_r.we) begin
      // load data wins over a post-increment of the same register
      rf_r[insn_r.rn] <= ld_ext;
    end
  end

  // condition flag, only compares touch it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (in_exec && (insn_r.op == `COA_OP_CMPEQ)) begin
      flag_r <= (rn_v == imm_s);
    end else if (in_exec && (insn_r.op == `COA_OP_CMPGE)) begin
      flag_r <= ($signed(rn_v) >= $signed(rm_v));
    end
  end

  // multiplier pipeline; result committed on the last cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mac_r  <= 64'h0000_0000_0000_0000;
      prod_r <= 64'h0000_0000_0000_0000;
      cnt_r  <= 2'h0;
    end else if (in_exec && need_mul) begin
      prod_r <= prod_nxt;
      cnt_r  <= lat;
    end else if (state_r == coa_pkg::ST_MUL) begin
      cnt_r <= cnt_r - 2'h1;
      if (cnt_r == 2'h1) mac_r <= prod_r;
    end
  end

  assign mem_o     = mem_r;
  assign cond_flag = flag_r;
  assign pc_o      = pc_r;
  assign mac_o     = mac_r;
  assign retire_o  = retire;

  a_bra_slot: assert property (
    retire && !pend_r && (insn_r.op == `COA_OP_BRA) |=>
      pend_r && (pc_r == $past(pc_r) + `COA_INSN_STEP))
    else $error("delay slot not fetched after branch");

  a_bra_target: assert property (
    retire && pend_r |=> !pend_r && (pc_r == $past(tgt_r)))
    else $error("branch target not taken after slot");

  a_mul16_time: assert property (
    in_exec && need_mul && (insn_r.sub[1:0] == `COA_MK_S16) |=>
      retire ##1 (mac_r[31:0] == $past(prod_r[31:0])))
    else $error("16-bit multiply latency wrong");

  a_mac16_time: assert property (
    in_exec && need_mul && (insn_r.sub[1:0] == `COA_MK_M16) |=> !retire ##1 retire)
    else $error("16-bit accumulate latency wrong");

  a_mul32_time: assert property (
    in_exec && need_mul && insn_r.sub[1] |=> !retire[*2] ##1 retire)
    else $error("32-bit multiply latency wrong");

  a_compare_greater_equal: assert property (
    in_exec && (insn_r.op == `COA_OP_CMPGE) |=>
      flag_r == ($signed($past(rn_v)) >= $signed($past(rm_v))))
    else $error("greater-equal compare wrong flag");

  a_flag_branch: assert property (
    retire && !pend_r && taken |=> pc_r == $past(br_tgt))
    else $error("conditional branch ignored flag");

  a_add_flag: assert property (
    in_exec && ((insn_r.op == `COA_OP_ADD) || (insn_r.op == `COA_OP_ADDI)) |=>
      $stable(flag_r))
    else $error("add changed the flag");

  a_compare_equal: assert property (
    in_exec && (insn_r.op == `COA_OP_CMPEQ) |=> flag_r == ($past(rn_v) == $past(imm_s)))
    else $error("equal compare wrong flag");

  a_imm_field: assert property (
    in_exec && (insn_r.op == `COA_OP_MOVI) |=>
      (rf_r[$past(insn_r.rn)] == $past(imm_s)) && (state_r == coa_pkg::ST_FETCH))
    else $error("byte immediate not from instruction");

  a_lit_fetch: assert property (
    in_exec && (insn_r.op == `COA_OP_LITL) |=>
      mem_r.req && !mem_r.we && (mem_r.addr == $past(lit_ea)))
    else $error("literal table not read");

  a_direct_mov: assert property (
    in_exec && (insn_r.op == `COA_OP_MOV) |=>
      (rf_r[$past(insn_r.rn)] == $past(rm_v)) && !mem_r.req)
    else $error("direct move wrong");

  a_ind_addr: assert property (
    in_exec && is_ldst && (am == `COA_AM_IND) |=>
      (mem_r.addr == $past(base_v)) && (rf_r[$past(base_idx)] == $past(base_v)))
    else $error("indirect address wrong");

  a_post_inc: assert property (
    in_exec && is_ldst && (am == `COA_AM_POST) |=>
      (mem_r.addr == $past(base_v)) && (rf_r[$past(base_idx)] == $past(base_v) + $past(step)))
    else $error("post-increment wrong");

  a_pre_dec: assert property (
    in_exec && is_ldst && (am == `COA_AM_PRE) |=>
      (mem_r.addr == $past(ea)) && (rf_r[$past(base_idx)] == $past(base_v) - $past(step)))
    else $error("pre-decrement wrong");

  a_idx_addr: assert property (
    in_exec && is_ldst && (am == `COA_AM_IDX) |=> mem_r.addr == $past(base_v) + $past(r0_v))
    else $error("indexed address wrong");

  a_sext_byte: assert property (
    (state_r == coa_pkg::ST_MEM) && mem_r.req && mem_ack && !mem_r.we &&
      (mem_r.size == `COA_SZ_B) |=>
      rf_r[$past(insn_r.rn)] == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])})
    else $error("byte load not sign-extended");

  c_bra_slot: cover property (retire && pend_r);
  c_mac32:    cover property (in_exec && need_mul && (insn_r.sub[1:0] == `COA_MK_M32));
  c_bt_taken: cover property (retire && !pend_r && taken);
  c_pre_dec:  cover property (in_exec && is_ldst && (am == `COA_AM_PRE));

endmodule : coa_core

// [pkg/coa_defines.svh]
`ifndef COA_DEFINES_SVH
`define COA_DEFINES_SVH

// opcode field, instruction bits 15:12
`define COA_OP_NOP   4'h0
`define COA_OP_MOVI  4'h1
`define COA_OP_ADDI  4'h2
`define COA_OP_CMPEQ 4'h3
`define COA_OP_ADD   4'h4
`define COA_OP_CMPGE 4'h5
`define COA_OP_MOV   4'h6
`define COA_OP_LD    4'h7
`define COA_OP_ST    4'h8
`define COA_OP_LITW  4'h9
`define COA_OP_LITL  4'hA
`define COA_OP_BRA   4'hB
`define COA_OP_BT    4'hC
`define COA_OP_BF    4'hD
`define COA_OP_MUL   4'hE

// access sizes, sub field bits 1:0
`define COA_SZ_B 2'h0
`define COA_SZ_W 2'h1
`define COA_SZ_L 2'h2

// addressing modes, sub field bits 3:2
`define COA_AM_IND  2'h0
`define COA_AM_POST 2'h1
`define COA_AM_PRE  2'h2
`define COA_AM_IDX  2'h3

// multiply kinds, sub field bits 1:0
`define COA_MK_S16  2'h0
`define COA_MK_M16  2'h1
`define COA_MK_S32  2'h2
`define COA_MK_M32  2'h3

// cycles spent in the multiply state after execute
`define COA_LAT_S16 2'h1
`define COA_LAT_M16 2'h2
`define COA_LAT_32  2'h3

// address steps
`define COA_STEP_B 32'h0000_0001
`define COA_STEP_W 32'h0000_0002
`define COA_STEP_L 32'h0000_0004
`define COA_INSN_STEP 32'h0000_0002

`define COA_IDX_REG 4'h0

`endif

// [pkg/coa_pkg.sv]
package coa_pkg;

  typedef enum logic [1:0] {
    ST_FETCH,
    ST_EXEC,
    ST_MEM,
    ST_MUL
  } coa_state_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } coa_mem_req_type;

  typedef struct packed {
    logic [3:0] op;
    logic [3:0] rn;
    logic [3:0] rm;
    logic [3:0] sub;
  } coa_insn_type;

endpackage : coa_pkg

// [dv/coa_mem_model.sv]
`timescale 1ns/100ps
// memory partner: one request at a time, ack after ack_delay waits
module coa_mem_model (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                rst,
  // core bus
  input coa_pkg::coa_mem_req_type mem_i,
  output logic                    mem_ack,
  output logic [31:0]             mem_rdata,
  // stall control
  input wire logic [3:0]          ack_delay
);
  logic [7:0]  mem [0:1023];
  logic [31:0] last_addr;
  logic [3:0]  wait_r;
  logic [9:0]  a;

  assign a = mem_i.addr[9:0];

  // rdata toggles outside the ack cycle so stale data never looks valid
  always @(posedge ref_clk) begin
    mem_rdata <= ~mem_rdata;
    mem_ack <= 1'b0;
    if (rst) begin
      wait_r    <= 4'h0;
      mem_rdata <= 32'h5a5a_5a5a;
    end else if (mem_i.req && !mem_ack) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r == ack_delay) begin
        mem_ack <= 1'b1;
        wait_r <= 4'h0;
        mem_rdata <= {mem[a + 10'h3], mem[a + 10'h2], mem[a + 10'h1], mem[a]};
        if (mem_i.we) begin
          last_addr <= mem_i.addr;
          for (int i = 0; i < 4; i++) begin
            if (i < (1 << mem_i.size)) mem[a + i[9:0]] <= mem_i.wdata[8*i +: 8];
          end
        end
      end
    end
  end
endmodule : coa_mem_model

// [dv/test_coa_core.sv]
`timescale 1ns/100ps
`include "coa_defines.svh"
module test_coa_core;
  localparam int DLY = 1;
  logic                     ref_clk = 1'b0;
  logic                     rst = 1'b1;
  logic [3:0]               ack_delay = 4'h0;
  logic                     mem_ack;
  logic                     cond_flag;
  logic                     retire_o;
  logic [31:0]              mem_rdata;
  logic [31:0]              pc_o;
  logic [63:0]              mac_o;
  coa_pkg::coa_mem_req_type mem_o;
  int                       num_errors = 0;
  int                       checked = 0;
  logic [15:0]              prog_q [$];

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  coa_core coa_core_inst (.ref_clk(ref_clk), .rst(rst), .mem_o(mem_o), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .cond_flag(cond_flag), .pc_o(pc_o), .mac_o(mac_o),
    .retire_o(retire_o));

  coa_mem_model coa_mem_model_inst (.ref_clk(ref_clk), .rst(rst), .mem_i(mem_o),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ack_delay(ack_delay));

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  // instruction word builders
  function automatic logic [15:0] ins(input logic [3:0] op, n, input logic [7:0] lo);
    return {op, n, lo};
  endfunction : ins

  function automatic logic [15:0] ma(input logic [3:0] op, n, m, input logic [1:0] am, sz);
    return {op, n, m, am, sz};
  endfunction : ma

  // memory is little-endian bytes
  function automatic logic [31:0] rdmem(input logic [9:0] a, input int n);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < n; i++) v[8*i +: 8] = coa_mem_model_inst.mem[a + i[9:0]];
    return v;
  endfunction : rdmem

  task automatic put(input logic [9:0] a, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) coa_mem_model_inst.mem[a + i[9:0]] = v[8*i +: 8];
  endtask : put

  // reset, clear memory, load program from address 0
  task automatic boot(input logic [3:0] dly);
    @(posedge ref_clk);
    #DLY;
    rst = 1'b1;
    ack_delay = dly;
    for (int i = 0; i < 1024; i++) coa_mem_model_inst.mem[i] = 8'h00;
    foreach (prog_q[i]) put(10'(2 * i), {16'h0, prog_q[i]}, 2);
    repeat (16) @(posedge ref_clk);
    #DLY;
    rst = 1'b0;
  endtask : boot

  // wait for n retirements, bounded; sampled mid-cycle to avoid edge races
  task automatic step(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge ref_clk);
        k++;
      end while (retire_o !== 1'b1 && k < 300);
      if (k >= 300) chk("retire wait", 64'h1, 64'h0);
      @(posedge ref_clk);
    end
    #DLY;
  endtask : step

  // cycles from instruction fetch ack to its retirement, sampled mid-cycle
  task automatic mstep(output int k);
    repeat (300) begin
      @(negedge ref_clk);
      if (mem_ack === 1'b1) break;
    end
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (retire_o !== 1'b1 && k < 300);
  endtask : mstep

  task automatic chk_st(input logic [31:0] a, input logic [31:0] d, input int n);
    chk("store address", a, coa_mem_model_inst.last_addr);
    chk("store data", d, rdmem(a[9:0], n));
  endtask : chk_st

  task automatic test_modes;
    prog_q = '{ins(`COA_OP_MOVI, 4'h1, 8'h40), ins(`COA_OP_MOVI, 4'h2, 8'h85),
      ma(`COA_OP_ST, 4'h1, 4'h2, `COA_AM_IND, `COA_SZ_L),
      ma(`COA_OP_ST, 4'h1, 4'h2, `COA_AM_POST, `COA_SZ_W),
      ma(`COA_OP_ST, 4'h1, 4'h2, `COA_AM_PRE, `COA_SZ_B),
      ma(`COA_OP_ST, 4'h1, 4'h1, `COA_AM_IND, `COA_SZ_L), ins(`COA_OP_MOVI, 4'h0, 8'h08),
      ma(`COA_OP_ST, 4'h1, 4'h2, `COA_AM_IDX, `COA_SZ_L), ins(`COA_OP_MOVI, 4'h6, 8'h60),
      ma(`COA_OP_LD, 4'h4, 4'h6, `COA_AM_POST, `COA_SZ_W),
      ma(`COA_OP_ST, 4'h6, 4'h4, `COA_AM_IND, `COA_SZ_L),
      ma(`COA_OP_LD, 4'h5, 4'h6, `COA_AM_IND, `COA_SZ_B),
      ma(`COA_OP_ST, 4'h6, 4'h5, `COA_AM_IND, `COA_SZ_L)};
    boot(4'h0);
    put(10'h060, 32'h3412_80f0, 4);
    step(3);
    chk_st(32'h0000_0040, 32'hffff_ff85, 4);
    step(1);
    chk_st(32'h0000_0040, 32'h0000_ff85, 2);
    step(1);
    chk_st(32'h0000_0041, 32'h0000_0085, 1);
    step(1);
    chk_st(32'h0000_0041, 32'h0000_0041, 4);
    step(2);
    chk_st(32'h0000_0049, 32'hffff_ff85, 4);
    step(3);
    chk_st(32'h0000_0062, 32'hffff_80f0, 4);
    step(2);
    chk_st(32'h0000_0062, 32'hffff_fff0, 4);
    $display("test_modes done");
  endtask : test_modes

  // slow memory: literal loads, indirect and indexed stores
  task automatic test_lit;
    prog_q = '{ins(`COA_OP_LITW, 4'h1, 8'h10), ins(`COA_OP_LITL, 4'h3, 8'h09),
      ma(`COA_OP_ST, 4'h3, 4'h1, `COA_AM_IND, `COA_SZ_L), ins(`COA_OP_LITW, 4'h0, 8'h0e),
      ma(`COA_OP_ST, 4'h3, 4'h1, `COA_AM_IDX, `COA_SZ_W)};
    boot(4'h3);
    put(10'h020, 32'h0010_8234, 4);
    put(10'h024, 32'h0000_0300, 4);
    step(3);
    chk_st(32'h0000_0300, 32'hffff_8234, 4);
    step(2);
    chk_st(32'h0000_0310, 32'h0000_8234, 2);
    $display("test_lit done");
  endtask : test_lit

  task automatic test_branch;
    prog_q = '{ins(`COA_OP_MOVI, 4'h1, 8'h05), ins(`COA_OP_MOVI, 4'h2, 8'h03),
      ins(`COA_OP_CMPGE, 4'h1, 8'h20), ins(`COA_OP_ADDI, 4'h1, 8'hfb),
      ins(`COA_OP_CMPEQ, 4'h1, 8'h00), ins(`COA_OP_BF, 4'h0, 8'h10),
      ins(`COA_OP_BT, 4'h0, 8'h04), 16'h0, 16'h0, 16'h0, ins(`COA_OP_CMPGE, 4'h1, 8'h20),
      ins(`COA_OP_BRA, 4'h0, 8'h10), ins(`COA_OP_MOVI, 4'h4, 8'h07)};
    boot(4'h1);
    put(10'h036, {16'h0, ma(`COA_OP_ST, 4'h1, 4'h4, `COA_AM_IND, `COA_SZ_L)}, 2);
    step(3);
    chk("flag", 64'h1, cond_flag);
    step(1);
    chk("flag", 64'h1, cond_flag);
    step(1);
    chk("flag", 64'h1, cond_flag);
    step(1);
    chk("pc", 64'h0c, pc_o);
    step(1);
    chk("pc", 64'h14, pc_o);
    step(1);
    chk("flag", 64'h0, cond_flag);
    step(1);
    chk("pc", 64'h18, pc_o);
    step(1);
    chk("pc", 64'h36, pc_o);
    step(1);
    chk_st(32'h0000_0000, 32'h0000_0007, 4);
    $display("test_branch done");
  endtask : test_branch

  // each multiply kind: latency then accumulator value
  task automatic test_mul;
    int k;
    int lat [4];
    logic signed [63:0] em;
    logic signed [63:0] p;
    lat = '{2, 3, 4, 4};
    em = 64'sh0;
    p = -64'sd3 * 64'sd127;
    prog_q = '{ins(`COA_OP_MOVI, 4'h1, 8'hfd), ins(`COA_OP_MOVI, 4'h2, 8'h7f)};
    for (int i = 0; i < 4; i++) prog_q.push_back(ma(`COA_OP_MUL, 4'h1, 4'h2, 2'h0, 2'(i)));
    boot(4'h0);
    step(2);
    for (int i = 0; i < 4; i++) begin
      mstep(k);
      chk("multiply cycles", 64'(lat[i]), 64'(k));
      case (i)
        0: em = {em[63:32], p[31:0]};
        2: em = p;
        default: em = em + p;
      endcase
      @(posedge ref_clk);
      #DLY;
      chk("accumulator", em, mac_o);
    end
    $display("test_mul done");
  endtask : test_mul

  task automatic summarize;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    test_modes();
    test_lit();
    test_branch();
    test_mul();
    summarize();
  end

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #40000;
    num_errors++;
    summarize();
  end
endmodule : test_coa_core
